// *** bdar_core.sv ***
`timescale 1ns/1ps
// Behaviour
// - 128 general registers of 64 bits, each with a validity tag
// - General register zero reads zero; writing it faults
// - Speculative writes may set the destination validity tag
// - 128 floating-point registers of 82 bits
// - FP registers zero and one read +0.0 and +1.0; writes fault
// - 64 one-bit predicates gate execution and branches
// - Predicate zero reads true; writes to it are silently dropped
// - Eight 64-bit branch registers supply indirect branch targets
// - 128 application registers; index 66 is the epilogue counter
// - 64-bit instruction pointer addresses the current bundle
// - Bundles are 128 bits holding exactly three instructions
// - Slots are 41 bits; five bits hold the template code
// - True guard commits, faults normally; false guard discards silently
// - Twelve basic templates, each with and without a final stop
// - Two templates place a stop after slot one or slot two
// - Groups end at every stop and every taken branch
// - A group may issue over several cycles
module bdar_core (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Bundle input
	input  wire logic                      bundle_valid,
	input  wire logic [bdar_pkg::BUNDLE_W-1:0] bundle,
	output logic                           bundle_ready,
	// Slot issue
	output logic                           issue_valid,
	output logic [bdar_pkg::SLOT_W-1:0]    issue_insn,
	output bdar_pkg::bdar_kind_t           issue_kind,
	output logic [1:0]                     issue_pos,
	output logic                           issue_commit,
	output logic                           issue_group_end,
	output logic [bdar_pkg::XLEN-1:0]      issue_ip,
	output logic                           group_close,
	// Taken branch
	input  wire logic                      branch_taken,
	input  wire logic [bdar_pkg::BSEL_W-1:0] branch_sel,
	// Result write
	input  wire logic                      wr_valid,
	input  wire bdar_pkg::bdar_file_t      wr_file,
	input  wire logic [bdar_pkg::IDX_W-1:0] wr_idx,
	input  wire logic [bdar_pkg::GUARD_W-1:0] wr_guard,
	input  wire logic [bdar_pkg::FR_W-1:0] wr_data,
	input  wire logic                      wr_nat,
	output logic                           wr_fault,
	// Register read
	input  wire bdar_pkg::bdar_file_t      rd_file,
	input  wire logic [bdar_pkg::IDX_W-1:0] rd_idx,
	output logic [bdar_pkg::FR_W-1:0]      rd_data,
	output logic                           rd_nat
);
	import bdar_pkg::*;

	typedef enum logic {ST_IDLE, ST_ISSUE} bdar_state_t;

	////////////////////////////////////////////////////////////////////////
	// Architectural state
	logic [XLEN-1:0]   gr  [GR_N];
	logic [GR_N-1:0]   nat;
	logic [FR_W-1:0]   fr  [FR_N];
	logic [PR_N-1:0]   pr;
	logic [XLEN-1:0]   br  [BR_N];
	logic [XLEN-1:0]   ar  [AR_N];
	logic [XLEN-1:0]   ip;

	logic              ctrl_en;
	logic [ST_W-1:0]   status;
	logic [31:0]       groups;
	bdar_state_t       state;
	logic [1:0]        pos;
	logic [BUNDLE_W-1:0] bundle_q;

	////////////////////////////////////////////////////////////////////////
	// Template lookup
	bdar_tmpl_if tif ();
	bdar_tmpl_decode u_tmpl (
		.t (tif)
	);
	assign tif.code = (state == ST_IDLE) ?
		bundle[TMPL_LSB +: TMPL_W] : bundle_q[TMPL_LSB +: TMPL_W];

	////////////////////////////////////////////////////////////////////////
	// APB decode
	logic        apb_wr;
	logic        apb_setup;
	logic        hit;
	logic        wr_ctrl;
	logic        wr_status;
	logic        wr_ip_lo;
	logic        wr_ip_hi;
	logic        wr_ec;
	logic [31:0] next_prdata;

	// Zero wait states: every access ends in its first access cycle
	assign pready    = 1'b1;
	assign apb_wr    = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign hit = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
		(paddr == REG_IP_LO) || (paddr == REG_IP_HI) ||
		(paddr == REG_EC) || (paddr == REG_GROUPS);
	assign pslverr   = psel && penable && !hit;
	assign wr_ctrl   = apb_wr && (paddr == REG_CTRL);
	assign wr_status = apb_wr && (paddr == REG_STATUS);
	assign wr_ip_lo  = apb_wr && (paddr == REG_IP_LO) && (state == ST_IDLE);
	assign wr_ip_hi  = apb_wr && (paddr == REG_IP_HI) && (state == ST_IDLE);
	assign wr_ec     = apb_wr && (paddr == REG_EC);
	assign next_prdata =
		(paddr == REG_CTRL)   ? {31'h0, ctrl_en} :
		(paddr == REG_STATUS) ? {28'h0, state == ST_ISSUE, status} :
		(paddr == REG_IP_LO)  ? ip[31:0] :
		(paddr == REG_IP_HI)  ? ip[63:32] :
		(paddr == REG_EC)     ? ar[EPILOGUE_IDX][31:0] :
		(paddr == REG_GROUPS) ? groups : 32'h0;

	always_ff @(posedge mclk) begin
		if (rst)
			prdata <= 32'h0;
		else if (apb_setup)
			prdata <= next_prdata;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			ctrl_en <= 1'b0;
		else if (wr_ctrl)
			ctrl_en <= pwdata[CTRL_EN_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Bundle sequencing
	logic [SLOT_W-1:0]  cur_slot;
	logic [GUARD_W-1:0] cur_guard;
	logic               accept;
	logic               issuing;
	logic               last_slot;
	logic               tmpl_bad;
	logic               stop_here;
	logic               take_ok;
	logic               group_end;

	assign bundle_ready = (state == ST_IDLE) && ctrl_en && !branch_taken;
	assign accept    = bundle_ready && bundle_valid;
	assign tmpl_bad  = accept && !tif.legal;
	// No dependence interlock: groups arrive hazard-free
	assign issuing   = (state == ST_ISSUE) && !branch_taken;
	assign last_slot = (pos == 2'(LAST_POS));
	assign cur_slot  =
		bundle_q[SLOT0_LSB + 32'(pos) * SLOT_W +: SLOT_W];
	assign cur_guard = cur_slot[GUARD_LSB +: GUARD_W];
	assign stop_here = tif.stop_after[pos];
	assign take_ok   = accept && tif.legal;
	assign group_end = (issuing && stop_here) || branch_taken;

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			pos   <= 2'h0;
		end else if (branch_taken) begin
			state <= ST_IDLE;
			pos   <= 2'h0;
		end else if (take_ok) begin
			state <= ST_ISSUE;
			pos   <= 2'h0;
		end else if (issuing) begin
			state <= last_slot ? ST_IDLE : ST_ISSUE;
			pos   <= last_slot ? 2'h0 : pos + 2'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst)
			bundle_q <= '0;
		else if (accept)
			bundle_q <= bundle;
	end

	// Pointer words load only while idle, so a bundle never sees a torn value
	always_ff @(posedge mclk) begin
		if (rst)
			ip <= '0;
		else if (branch_taken)
			ip <= br[branch_sel];
		else if (issuing && last_slot)
			ip <= ip + IP_BUNDLE_STEP;
		else if (wr_ip_lo)
			ip[31:0] <= pwdata;
		else if (wr_ip_hi)
			ip[63:32] <= pwdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Issue outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			issue_valid     <= 1'b0;
			issue_insn      <= '0;
			issue_kind      <= SK_M;
			issue_pos       <= 2'h0;
			issue_commit    <= 1'b0;
			issue_group_end <= 1'b0;
			issue_ip        <= '0;
			group_close     <= 1'b0;
		end else begin
			issue_valid     <= issuing;
			issue_insn      <= cur_slot;
			issue_kind      <= tif.kind[pos];
			issue_pos       <= pos;
			issue_commit    <= pr[cur_guard];
			issue_group_end <= issuing && stop_here;
			issue_ip        <= ip;
			group_close     <= group_end;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst)
			groups <= 32'h0;
		else if (group_end)
			groups <= groups + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Result writes
	logic guard_ok;
	logic wr_go;
	logic gr_fault;
	logic fr_fault;
	logic gr_we;
	logic fr_we;
	logic pr_we;
	logic br_we;
	logic ar_we;

	assign guard_ok = pr[wr_guard];
	assign wr_go    = wr_valid && guard_ok;
	assign gr_fault = wr_go && (wr_file == RF_GR) &&
		(wr_idx == ZERO_GPR_IDX);
	assign fr_fault = wr_go && (wr_file == RF_FR) &&
		((wr_idx == FP_CONST_ZERO_IDX) ||
		(wr_idx == FP_CONST_ONE_IDX));
	assign gr_we    = wr_go && (wr_file == RF_GR) && !gr_fault;
	assign fr_we    = wr_go && (wr_file == RF_FR) && !fr_fault;
	assign pr_we    = wr_go && (wr_file == RF_PR);
	assign br_we    = wr_go && (wr_file == RF_BR);
	assign ar_we    = wr_go && (wr_file == RF_AR);

	always_ff @(posedge mclk) begin
		if (gr_we)
			gr[wr_idx] <= wr_data[XLEN-1:0];
	end

	always_ff @(posedge mclk) begin
		if (rst)
			nat <= '0;
		else if (gr_we)
			nat[wr_idx] <= wr_nat;
	end

	always_ff @(posedge mclk) begin
		if (fr_we)
			fr[wr_idx] <= wr_data;
	end

	// Entry zero resets true and ignores writes, so results aimed at it vanish
	for (genvar k = 0; k < PR_N; k++) begin : g_pred
		always_ff @(posedge mclk) begin
			if (rst)
				pr[k] <= (k == int'(GUARD_TRUE_IDX));
			else if (pr_we && (k != int'(GUARD_TRUE_IDX)) &&
				(wr_idx[GUARD_W-1:0] == GUARD_W'(k)))
				pr[k] <= wr_data[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (br_we)
			br[wr_idx[BSEL_W-1:0]] <= wr_data[XLEN-1:0];
	end

	always_ff @(posedge mclk) begin
		if (wr_ec)
			ar[EPILOGUE_IDX] <= {32'h0, pwdata};
		else if (ar_we)
			ar[wr_idx] <= wr_data[XLEN-1:0];
	end

	always_ff @(posedge mclk) begin
		if (rst)
			wr_fault <= 1'b0;
		else
			wr_fault <= gr_fault || fr_fault;
	end

	// Sticky faults, write one to clear; a new fault wins over the clear
	always_ff @(posedge mclk) begin
		if (rst)
			status <= '0;
		else
			status <= (status & ~(wr_status ? pwdata[ST_W-1:0] : 3'h0)) |
				{tmpl_bad, fr_fault, gr_fault};
	end

	////////////////////////////////////////////////////////////////////////
	// Register read port
	logic [FR_W-1:0] next_rd;
	logic            next_nat;

	// Hardwired GR and FR entries are decoded here; predicate zero is read from its reset-true storage
	assign next_rd =
		(rd_file == RF_GR) ? ((rd_idx == ZERO_GPR_IDX) ? FP_PLUS_ZERO :
			{18'h0, gr[rd_idx]}) :
		(rd_file == RF_FR) ? ((rd_idx == FP_CONST_ZERO_IDX) ? FP_PLUS_ZERO :
			(rd_idx == FP_CONST_ONE_IDX) ? FP_PLUS_ONE : fr[rd_idx]) :
		(rd_file == RF_PR) ? {81'h0, pr[rd_idx[GUARD_W-1:0]]} :
		(rd_file == RF_BR) ? {18'h0, br[rd_idx[BSEL_W-1:0]]} :
		(rd_file == RF_AR) ? {18'h0, ar[rd_idx]} : FP_PLUS_ZERO;
	assign next_nat = (rd_file == RF_GR) && (rd_idx != ZERO_GPR_IDX) &&
		nat[rd_idx];

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_data <= '0;
			rd_nat  <= 1'b0;
		end else begin
			rd_data <= next_rd;
			rd_nat  <= next_nat;
		end
	end
endmodule

// *** bdar_pkg.sv ***
package bdar_pkg;
	localparam int GR_N      = 128;
	localparam int FR_N      = 128;
	localparam int PR_N      = 64;
	localparam int BR_N      = 8;
	localparam int AR_N      = 128;
	localparam int XLEN      = 64;
	localparam int FR_W      = 82;
	localparam int SLOT_W    = 41;
	localparam int TMPL_W    = 5;
	localparam int BUNDLE_W  = 128;
	localparam int GUARD_W   = 6;
	localparam int IDX_W     = 7;
	localparam int BSEL_W    = 3;
	localparam int TMPL_LSB  = 0;
	localparam int SLOT0_LSB = 5;
	localparam int GUARD_LSB = 0;
	localparam int BASIC_N   = 12;
	localparam int LAST_POS  = 2;

	localparam logic [IDX_W-1:0]   ZERO_GPR_IDX      = 7'h00;
	localparam logic [IDX_W-1:0]   FP_CONST_ZERO_IDX = 7'h00;
	localparam logic [IDX_W-1:0]   FP_CONST_ONE_IDX  = 7'h01;
	localparam logic [GUARD_W-1:0] GUARD_TRUE_IDX    = 6'h00;
	localparam logic [IDX_W-1:0]   EPILOGUE_IDX      = 7'h42;
	// Sign, 17-bit exponent, 64-bit significand with explicit integer bit
	localparam logic [FR_W-1:0] FP_PLUS_ZERO = 82'h0;
	localparam logic [FR_W-1:0] FP_PLUS_ONE  =
		{1'b0, 17'h0FFFF, 64'h8000000000000000};
	localparam logic [XLEN-1:0] IP_BUNDLE_STEP = 64'h10;

	// APB map
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_IP_LO  = 12'h008;
	localparam logic [11:0] REG_IP_HI  = 12'h00C;
	localparam logic [11:0] REG_EC     = 12'h010;
	localparam logic [11:0] REG_GROUPS = 12'h014;
	localparam int CTRL_EN_BIT   = 0;
	localparam int ST_GR_FAULT   = 0;
	localparam int ST_FR_FAULT   = 1;
	localparam int ST_TMPL_FAULT = 2;
	localparam int ST_BUSY       = 3;
	localparam int ST_W          = 3;

	typedef enum logic [2:0] {SK_M, SK_I, SK_F, SK_B, SK_L, SK_X} bdar_kind_t;
	typedef enum logic [2:0] {RF_GR, RF_FR, RF_PR, RF_BR, RF_AR} bdar_file_t;

	// Basic template index is code[4:1]; code[0] marks a stop after slot 3
	localparam logic [3:0] TMPL_MII                = 4'h0;
	localparam logic [3:0] TMPL_SPLIT_AFTER_FIRST  = 4'h1;
	localparam logic [3:0] TMPL_LONG_IMMEDIATE     = 4'h2;
	localparam logic [3:0] TMPL_SPLIT_AFTER_SECOND = 4'h4;
	localparam logic [8:0] TMPL_KINDS [BASIC_N] = '{
		{SK_M, SK_I, SK_I}, {SK_M, SK_I, SK_I}, {SK_M, SK_L, SK_X},
		{SK_M, SK_M, SK_I}, {SK_M, SK_M, SK_I}, {SK_M, SK_F, SK_I},
		{SK_M, SK_M, SK_F}, {SK_M, SK_I, SK_B}, {SK_M, SK_B, SK_B},
		{SK_B, SK_B, SK_B}, {SK_M, SK_M, SK_B}, {SK_M, SK_F, SK_B}};
endpackage

// *** bdar_tmpl_if.sv ***
`timescale 1ns/1ps
interface bdar_tmpl_if;
	import bdar_pkg::*;
	logic [TMPL_W-1:0] code;
	logic              legal;
	bdar_kind_t        kind [3];
	logic [2:0]        stop_after;
	modport table_side (input code, output legal, kind, stop_after);
	modport user_side  (output code, input legal, kind, stop_after);
endinterface

// *** bdar_tmpl_decode.sv ***
`timescale 1ns/1ps
module bdar_tmpl_decode (
	// Template lookup
	bdar_tmpl_if.table_side t
);
	import bdar_pkg::*;

	logic [3:0] basic;
	logic [8:0] kinds;

	assign basic   = t.code[TMPL_W-1:1];
	assign t.legal = (32'(basic) < BASIC_N);
	assign kinds   = t.legal ? TMPL_KINDS[basic] : 9'h000;
	assign t.kind[0] = bdar_kind_t'(kinds[8:6]);
	assign t.kind[1] = bdar_kind_t'(kinds[5:3]);
	assign t.kind[2] = bdar_kind_t'(kinds[2:0]);
	assign t.stop_after[0] = (basic == TMPL_SPLIT_AFTER_FIRST);
	assign t.stop_after[1] = (basic == TMPL_SPLIT_AFTER_SECOND);
	assign t.stop_after[2] = t.code[0];
endmodule

// *** bdar_asserts.sv ***
`timescale 1ns/1ps
module bdar_asserts (
	// Clock and reset
	input wire logic			mclk,
	input wire logic			rst,
	// Bundle flow
	input wire logic			bundle_valid,
	input wire logic			bundle_ready,
	input wire logic [bdar_pkg::BUNDLE_W-1:0]	bundle,
	input wire logic			branch_taken,
	input wire logic			issue_valid,
	input wire logic [1:0]			issue_pos,
	input wire logic			issue_group_end,
	input wire logic			group_close,
	// Register ports
	input wire logic			wr_valid,
	input wire bdar_pkg::bdar_file_t	wr_file,
	input wire logic [6:0]			wr_idx,
	input wire logic [5:0]			wr_guard,
	input wire logic			wr_fault,
	input wire bdar_pkg::bdar_file_t	rd_file,
	input wire logic [6:0]			rd_idx,
	input wire logic [81:0]			rd_data
);
	import bdar_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_take_issue: assert property (bundle_valid && bundle_ready
		&& 32'(bundle[TMPL_LSB+1 +: TMPL_W-1]) < BASIC_N
		##1 !branch_taken |-> ##1 issue_valid && issue_pos == 2'h0)
		else $error("first slot late");
	chk_busy_hold: assert property (issue_valid
		&& issue_pos != 2'(LAST_POS) |-> !bundle_ready)
		else $error("bundle taken while issuing");
	chk_slot_next: assert property (issue_valid && issue_pos == 2'h0
		&& !branch_taken |=> issue_valid && issue_pos == 2'h1)
		else $error("second slot missing");
	chk_zero_gpr: assert property (rd_file == RF_GR
		&& rd_idx == ZERO_GPR_IDX |=> rd_data[63:0] == 64'h0)
		else $error("zero register not zero");
	chk_fp_one: assert property (rd_file == RF_FR
		&& rd_idx == FP_CONST_ONE_IDX |=> rd_data == FP_PLUS_ONE)
		else $error("fp one constant wrong");
	chk_guard_true: assert property (rd_file == RF_PR
		&& rd_idx == 7'h00 |=> rd_data[0])
		else $error("guard zero not true");
	chk_gpr0_fault: assert property (wr_valid && wr_file == RF_GR
		&& wr_idx == 7'h00 && wr_guard == GUARD_TRUE_IDX |=> wr_fault)
		else $error("zero register write did not fault");
	chk_stop_close: assert property (issue_valid && issue_group_end
		|-> group_close)
		else $error("stop did not close group");
	cov_fault: cover property (wr_fault);
	cov_mid_stop: cover property (issue_valid && issue_group_end
		&& issue_pos != 2'h2);
	cov_branch: cover property (branch_taken ##1 group_close);
endmodule

bind bdar_core bdar_asserts u_chk (.mclk, .rst, .bundle_valid, .bundle_ready,
	.bundle, .branch_taken, .issue_valid, .issue_pos, .issue_group_end,
	.group_close,
	.wr_valid, .wr_file, .wr_idx, .wr_guard, .wr_fault, .rd_file, .rd_idx,
	.rd_data);

// *** bdar_bundle_src.sv ***
`timescale 1ns/1ps
module bdar_bundle_src (
	// Clock and reset
	input wire logic		mclk,
	input wire logic		rst,
	// Request from the bench
	input wire logic		go,
	input wire logic [4:0]		code,
	input wire logic [122:0]	slots,
	// Bundle stream
	input wire logic		bundle_ready,
	output logic			bundle_valid,
	output logic [127:0]		bundle
);
	// Released bus shows the inverse of the last bundle
	always_ff @(posedge mclk) begin
		if (rst) begin
			bundle_valid <= 1'h0;
			bundle <= '1;
		end else if (go) begin
			bundle_valid <= 1'h1;
			bundle <= {slots, code};
		end else if (bundle_valid && bundle_ready) begin
			bundle_valid <= 1'h0;
			bundle <= ~bundle;
		end
	end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import bdar_pkg::*;
	logic		mclk, rst, psel, penable, pwrite, pready, pslverr, pe;
	logic		bundle_valid, bundle_ready, issue_valid, issue_commit;
	logic		issue_group_end, group_close, branch_taken, go;
	logic		wr_valid, wr_nat, wr_fault, rd_nat;
	logic [1:0]	issue_pos;
	logic [2:0]	branch_sel;
	logic [4:0]	code;
	logic [5:0]	wr_guard;
	logic [6:0]	wr_idx, rd_idx;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rv;
	logic [40:0]	issue_insn, q [$];
	logic [63:0]	issue_ip, ip;
	logic [81:0]	wr_data, rd_data, d, m [5][128];
	logic [122:0]	slots;
	logic [127:0]	bundle;
	bdar_kind_t	issue_kind;
	bdar_file_t	wr_file, rd_file, f;
	logic		m_nat [128], pred [64];
	int		failures, check_count, cyc, groups, seed, i;
	bdar_kind_t	kt [12][3] = '{'{SK_M, SK_I, SK_I}, '{SK_M, SK_I, SK_I},
		'{SK_M, SK_L, SK_X}, '{SK_M, SK_M, SK_I}, '{SK_M, SK_M, SK_I},
		'{SK_M, SK_F, SK_I}, '{SK_M, SK_M, SK_F}, '{SK_M, SK_I, SK_B},
		'{SK_M, SK_B, SK_B}, '{SK_B, SK_B, SK_B}, '{SK_M, SK_M, SK_B},
		'{SK_M, SK_F, SK_B}};

	bdar_core u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .bundle_valid, .bundle, .bundle_ready,
		.issue_valid, .issue_insn, .issue_kind, .issue_pos, .issue_commit,
		.issue_group_end, .issue_ip, .group_close, .branch_taken,
		.branch_sel, .wr_valid, .wr_file, .wr_idx, .wr_guard, .wr_data,
		.wr_nat, .wr_fault, .rd_file, .rd_idx, .rd_data, .rd_nat);
	bdar_bundle_src u_src (.mclk, .rst, .go, .code, .slots, .bundle_ready,
		.bundle_valid, .bundle);

	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			failures++;
			end_sim;
		end
	end
	////////////////////////////////////////////////////////////////////
	task end_sim;
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [81:0] got, input logic [81:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rv = prdata;
		pe = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Model is updated first, then the write is driven
	task wr(input bdar_file_t t, input int x, input int g,
		input logic [81:0] v, input logic n);
		logic c, flt;
		c = pred[g];
		flt = c && (t == RF_GR && x == 0 || t == RF_FR && x < 2);
		if (c && !flt && t != RF_PR)
			m[t][x] = t == RF_FR ? v : {18'h0, v[63:0]};
		if (c && !flt && t == RF_GR)
			m_nat[x] = n;
		if (c && t == RF_PR && x != 0)
			pred[x] = v[0];
		@(posedge mclk);
		wr_valid <= 1'h1;
		wr_file <= t;
		wr_idx <= x[6:0];
		wr_guard <= g[5:0];
		wr_data <= v;
		wr_nat <= n;
		@(posedge mclk);
		wr_valid <= 1'h0;
		@(negedge mclk);
		chk(wr_fault, flt);
	endtask
	task rd(input bdar_file_t t, input int x);
		logic g;
		g = t == RF_GR;
		@(posedge mclk);
		rd_file <= t;
		rd_idx <= x[6:0];
		@(posedge mclk);
		@(negedge mclk);
		if (t == RF_PR)
			chk(rd_data[0], pred[x]);
		else if (t == RF_FR)
			chk(rd_data, m[t][x]);
		else
			chk({g && rd_nat, rd_data[63:0]}, {g && m_nat[x], m[t][x][63:0]});
	endtask
	task bun(input logic [4:0] c, input logic br);
		logic [40:0]	e;
		logic		ge;
		int		n;
		n = 0;
		@(posedge mclk);
		for (int j = 0; j < 3; j++) begin
			e = 41'({$random(seed), $random(seed)});
			q.push_back(e);
			slots[j*41 +: 41] <= e;
		end
		code <= c;
		go <= 1'h1;
		@(posedge mclk);
		go <= 1'h0;
		repeat (14) begin
			@(negedge mclk);
			if (issue_valid === 1'h1) begin
				e = q.pop_front();
				ge = n == 2 && c[0] || n == 0 && c[4:1] == TMPL_SPLIT_AFTER_FIRST
					|| n == 1 && c[4:1] == TMPL_SPLIT_AFTER_SECOND;
				groups += ge;
				chk(issue_pos, n);
				chk(issue_insn, e);
				chk(issue_kind, kt[c[4:1]][n]);
				chk(issue_commit, pred[e[5:0]]);
				chk(issue_group_end, ge);
				chk(group_close, ge);
				chk(issue_ip, ip);
				n++;
				if (br) begin
					@(posedge mclk);
					branch_taken <= 1'h1;
					branch_sel <= 3'h3;
					@(posedge mclk);
					branch_taken <= 1'h0;
					ip = m[RF_BR][3][63:0];
					groups++;
					@(negedge mclk);
					chk(group_close, 1'h1);
					break;
				end
			end
		end
		chk(n, br ? 1 : c[4:1] < BASIC_N ? 3 : 0);
		chk(bundle_ready, 1'h1);
		if (!br && c[4:1] < BASIC_N)
			ip += IP_BUNDLE_STEP;
		q = {};
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 25683;
		rst = 1'h1;
		{psel, penable, pwrite, go, branch_taken, wr_valid, wr_nat} = '0;
		{paddr, pwdata, code, slots, branch_sel, wr_guard} = '0;
		{wr_idx, rd_idx, wr_data} = '0;
		wr_file = RF_GR;
		rd_file = RF_GR;
		foreach (pred[k])
			pred[k] = k == 0;
		m_nat = '{default: 1'h0};
		m[RF_GR][0] = '0;
		m[RF_FR][0] = FP_PLUS_ZERO;
		m[RF_FR][1] = FP_PLUS_ONE;
		repeat (6) @(posedge mclk);
		rst <= 1'h0;
		apb(1'h0, 12'h040, 32'h0);
		chk({pe, rv}, 33'h100000000);
		// Constant entries: write with a true guard, then read back
		for (int k = 0; k < 4; k++) begin
			f = k == 0 ? RF_GR : k == 3 ? RF_PR : RF_FR;
			wr(f, k == 2, 0, '1, 1'h1);
			rd(f, k == 2);
		end
		apb(1'h0, REG_STATUS, 32'h0);
		chk(rv, 32'h3);
		repeat (60) begin
			f = bdar_file_t'($unsigned($random(seed)) % 5);
			i = $unsigned($random(seed)) %
				(f == RF_BR ? BR_N : f == RF_PR ? PR_N : GR_N);
			if (f == RF_AR)
				i = EPILOGUE_IDX;
			d = 82'({$random(seed), $random(seed), $random(seed)});
			wr(f, i, 0, d, d[70]);
			wr(f, i, d[75:70], ~d, d[71]);
			rd(f, i);
		end
		apb(1'h1, REG_EC, d[31:0]);
		m[RF_AR][EPILOGUE_IDX] = {50'h0, d[31:0]};
		rd(RF_AR, EPILOGUE_IDX);
		apb(1'h1, REG_STATUS, 32'h3);
		apb(1'h1, REG_CTRL, 32'h1);
		apb(1'h1, REG_IP_LO, {d[31:4], 4'h0});
		apb(1'h1, REG_IP_HI, d[63:32]);
		ip = {d[63:32], d[31:4], 4'h0};
		for (int c = 0; c < 32; c++) begin
			bun(c[4:0], 1'h0);
			if (c >= 24) begin
				apb(1'h0, REG_STATUS, 32'h0);
				chk(rv, 32'h4);
				apb(1'h1, REG_STATUS, 32'h4);
			end
		end
		wr(RF_BR, 3, 0, d, 1'h0);
		bun(5'h0, 1'h1);
		bun(5'h9, 1'h0);
		apb(1'h0, REG_GROUPS, 32'h0);
		chk(rv, groups);
		end_sim;
	end
endmodule
